// ---- common/shift_right_ext_regs.vh ----
`ifndef SHIFT_RIGHT_EXT_REGS_VH
`define SHIFT_RIGHT_EXT_REGS_VH

// instruction encodings
`define OPC_PRIMARY        6'd31
`define XOP_DWORD_SHIFT    10'd539
`define XOP_EXT_ZERO       10'd665
`define XOP_EXT_SIGN       10'd921

// operand widths and field limits
`define DWORD_W            64
`define WORD_W             32
`define DW_AMT_W           7
`define WD_AMT_W           5
`define DW_AMT_OVER_BIT    6

// apb register byte offsets
`define ADDR_CTRL          8'h00
`define ADDR_AUX           8'h04
`define ADDR_EXCEPT        8'h08
`define ADDR_STATUS        8'h0c

// field positions
`define CTRL_MODE64_BIT    0
`define EXC_CARRY_BIT      0
`define EXC_SUMOVF_BIT     1
`define STAT_COND_LSB      0
`define STAT_COND_MSB      3
`define STAT_ILLEGAL_BIT   4

// condition field bit order {negative, positive, zero, summary}
`define COND_NEG_BIT       3
`define COND_POS_BIT       2
`define COND_ZERO_BIT      1
`define COND_SUM_BIT       0

// reset values
`define RST_AUX            32'h0000_0000
`define RST_COND           4'h0

`endif

// ---- hdl/ext_word_mask.v ----
`timescale 1ns/1ns
`include "shift_right_ext_regs.vh"

// rotate, mask and fill for the two extended word shifts
module ext_word_mask #(
  parameter W = 32
) (
  // operands
  input  wire [W-1:0] word_i,
  input  wire [4:0]   amount_i,
  input  wire         sign_fill_i,
  // results
  output wire [W-1:0] rotated_o,
  output wire [W-1:0] merged_o,
  output wire         carry_o
);

  wire [W-1:0] mask;
  wire [W-1:0] fill;
  wire [W-1:0] lost;
  wire [2*W-1:0] doubled;

  // rotate left by W-N is the same as rotate right by N
  assign doubled   = {word_i, word_i};
  assign rotated_o = doubled[amount_i +: W];

  // sign word: every bit is the source sign, else zero fill
  assign fill = {W{sign_fill_i & word_i[W-1]}};

  // per-bit mask and merge; bit index counts from the lsb
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign mask[i]     = (i < W - amount_i);
      assign merged_o[i] = mask[i] ? rotated_o[i] : fill[i];
      assign lost[i]     = rotated_o[i] & ~mask[i];
    end
  endgenerate

  // carry only matters for a negative source losing ones
  assign carry_o = (|lost) & word_i[W-1];

endmodule // ext_word_mask

// ---- hdl/cond_zero_eval.v ----
`timescale 1ns/1ns
`include "shift_right_ext_regs.vh"

// condition field value from a signed compare with zero
module cond_zero_eval #(
  parameter W = 64
) (
  // result under test
  input  wire [W-1:0] dword_i,
  input  wire         word_only_i,
  input  wire         sum_ovf_i,
  // field value
  output wire [3:0]   cond_o
);

  wire neg;
  wire zero;

  // word results are judged on their low half only
  assign neg  = word_only_i ? dword_i[`WORD_W-1] : dword_i[W-1];
  assign zero = word_only_i ? ~|dword_i[`WORD_W-1:0] : ~|dword_i;

  // exactly one of the three compare flags, summary copied
  assign cond_o = {neg, ~neg & ~zero, zero, sum_ovf_i};

endmodule // cond_zero_eval

// ---- hdl/shift_right_ext_unit.v ----
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "shift_right_ext_regs.vh"

module shift_right_ext_unit #(
  parameter       IMPL_64 = 1,
  parameter [4:0] IDX_W   = 5
) (
  // clock and reset
  input  wire                 SYS_CLK_I,
  input  wire                 RESET_I,
  // apb slave
  input  wire                 PSEL_I,
  input  wire                 PENABLE_I,
  input  wire                 PWRITE_I,
  input  wire [7:0]           PADDR_I,
  input  wire [31:0]          PWDATA_I,
  output reg  [31:0]          PRDATA_O,
  output reg                  PREADY_O,
  output reg                  PSLVERR_O,
  // issue from decode
  input  wire                 ISSUE_VALID_I,
  input  wire [5:0]           PRIMARY_OP_I,
  input  wire [9:0]           EXTENDED_OP_I,
  input  wire                 RECORD_BIT_I,
  input  wire [IDX_W-1:0]     DEST_IDX_I,
  input  wire [63:0]          SOURCE_GPR_I,
  input  wire [63:0]          AMOUNT_GPR_I,
  // write back
  output reg                  DONE_O,
  output reg                  DEST_WE_O,
  output reg  [IDX_W-1:0]     DEST_IDX_O,
  output reg  [63:0]          DEST_GPR_O,
  output reg                  COND_WE_O,
  output reg  [3:0]           COND_FIELD_ZERO_O,
  output reg                  SHIFT_OUT_WE_O,
  output reg                  SHIFT_OUT_FLAG_O,
  output reg  [31:0]          AUX_REG_O,
  output reg                  ILLEGAL_INSTR_O
);

  // decoded instruction kinds
  localparam [1:0] OP_NONE = 2'd0;
  localparam [1:0] OP_DW   = 2'd1;
  localparam [1:0] OP_EXZ  = 2'd2;
  localparam [1:0] OP_EXS  = 2'd3;

  // architected state held in this block
  reg                mode64_q;
  reg                mode64_d;
  reg  [31:0]        aux_q;
  reg  [31:0]        aux_d;
  reg                carry_q;
  reg                carry_d;
  reg                sum_ovf_q;
  reg                sum_ovf_d;
  reg  [3:0]         cond_q;
  reg  [3:0]         cond_d;
  reg                illegal_seen_q;
  reg                illegal_seen_d;

  // decode and datapath
  reg  [1:0]         op_kind;
  wire               is_ours;
  wire [6:0]         dw_amount;
  reg  [63:0]        dw_result;
  wire [31:0]        ext_rot;
  wire [31:0]        ext_merged;
  wire               ext_carry;
  reg  [63:0]        result;
  wire [3:0]         cond_new;
  wire               illegal;
  wire               exec;
  wire               word_exec;
  wire               sign_exec;
  wire               rec_exec;

  // apb
  wire               apb_access;
  wire               apb_wr;
  wire               apb_rd;
  wire               apb_done;
  reg                addr_ok;
  reg  [31:0]        rd_mux;

  // ------------------------------------------------------------------
  // decode: only the three shifts handled here, others are ignored
  // neighbouring shift opcodes fall through to none and are left alone
  always @* begin
    op_kind = OP_NONE;
    if (ISSUE_VALID_I && PRIMARY_OP_I == `OPC_PRIMARY) begin
      case (EXTENDED_OP_I)
        `XOP_DWORD_SHIFT: op_kind = OP_DW;
        `XOP_EXT_ZERO:    op_kind = OP_EXZ;
        `XOP_EXT_SIGN:    op_kind = OP_EXS;
        default:          op_kind = OP_NONE;
      endcase
    end
  end

  assign is_ours = (op_kind != OP_NONE);
  // doubleword form trapped when running as a 32-bit implementation
  assign illegal = (op_kind == OP_DW) && !mode64_q;
  assign exec    = is_ours && !illegal;

  // qualified strobes for the state update; sign_exec and rec_exec also feed the write-back pulses
  assign word_exec = exec && (op_kind != OP_DW);
  assign sign_exec = exec && (op_kind == OP_EXS);
  assign rec_exec  = exec && RECORD_BIT_I;

  // doubleword logical shift, bit 6 of the amount forces zero
  // a six-bit shifter alone would wrap amounts 64 to 127 back into range
  assign dw_amount = AMOUNT_GPR_I[`DW_AMT_W-1:0];

  always @* begin
    if (dw_amount[`DW_AMT_OVER_BIT]) begin
      dw_result = 64'h0000_0000_0000_0000;
    end else begin
      dw_result = SOURCE_GPR_I >> dw_amount[`DW_AMT_OVER_BIT-1:0];
    end
  end

  // one word engine serves both extended shifts
  ext_word_mask #(
    .W (`WORD_W)
  ) u_word (
    .word_i      (SOURCE_GPR_I[`WORD_W-1:0]),
    .amount_i    (AMOUNT_GPR_I[`WD_AMT_W-1:0]),
    .sign_fill_i (op_kind == OP_EXS),
    .rotated_o   (ext_rot),
    .merged_o    (ext_merged),
    .carry_o     (ext_carry)
  );

  // word results land zero extended in the destination
  always @* begin
    if (op_kind == OP_DW) begin
      result = dw_result;
    end else begin
      result = {32'h0000_0000, ext_merged};
    end
  end

  // summary copied from the exception register as it stands now
  cond_zero_eval #(
    .W (`DWORD_W)
  ) u_cond (
    .dword_i     (result),
    .word_only_i (op_kind != OP_DW),
    .sum_ovf_i   (sum_ovf_q),
    .cond_o      (cond_new)
  );

  // ------------------------------------------------------------------
  // apb: one wait state, pready raised in the second access cycle
  assign apb_access = PSEL_I && PENABLE_I && !PREADY_O;
  assign apb_rd     = apb_access && !PWRITE_I;

  // writes commit only at the edge that completes the transfer, so
  // nothing changes before the master has seen pready
  assign apb_done   = PSEL_I && PENABLE_I && PREADY_O;
  assign apb_wr     = apb_done && PWRITE_I;

  // address decode, unmapped offsets answer with slave error
  always @* begin
    case (PADDR_I)
      `ADDR_CTRL:   addr_ok = 1'b1;
      `ADDR_AUX:    addr_ok = 1'b1;
      `ADDR_EXCEPT: addr_ok = 1'b1;
      `ADDR_STATUS: addr_ok = 1'b1;
      default:      addr_ok = 1'b0;
    endcase
  end

  // read mux; unused bits read as zero so software may mask loosely
  always @* begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      `ADDR_CTRL:   rd_mux[`CTRL_MODE64_BIT] = mode64_q;
      `ADDR_AUX:    rd_mux = aux_q;
      `ADDR_EXCEPT: begin
        rd_mux[`EXC_CARRY_BIT]  = carry_q;
        rd_mux[`EXC_SUMOVF_BIT] = sum_ovf_q;
      end
      `ADDR_STATUS: begin
        rd_mux[`STAT_COND_MSB:`STAT_COND_LSB] = cond_q;
        rd_mux[`STAT_ILLEGAL_BIT]             = illegal_seen_q;
      end
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // next state: an instruction in the same cycle beats a bus write
  always @* begin
    mode64_d       = mode64_q;
    aux_d          = aux_q;
    carry_d        = carry_q;
    sum_ovf_d      = sum_ovf_q;
    cond_d         = cond_q;
    illegal_seen_d = illegal_seen_q;
    if (apb_wr) begin
      case (PADDR_I)
        `ADDR_CTRL:   mode64_d = PWDATA_I[`CTRL_MODE64_BIT];
        `ADDR_AUX:    aux_d = PWDATA_I;
        `ADDR_EXCEPT: begin
          carry_d   = PWDATA_I[`EXC_CARRY_BIT];
          sum_ovf_d = PWDATA_I[`EXC_SUMOVF_BIT];
        end
        // writing the status word clears the sticky illegal flag
        `ADDR_STATUS: illegal_seen_d = 1'b0;
        default:      mode64_d = mode64_q;
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (illegal) begin
      illegal_seen_d = 1'b1;
    end

    // both word shifts leave the rotated word behind
    if (word_exec) begin
      aux_d = ext_rot;
    end

    // only the sign-fill form touches carry
    if (sign_exec) begin
      carry_d = ext_carry;
    end

    // condition field written only by recording forms
    if (rec_exec) begin
      cond_d = cond_new;
    end
  end

  // ------------------------------------------------------------------
  // state registers
  // reset returns mode64 to the build choice, not to the last value written
  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      mode64_q       <= (IMPL_64 != 0);
      aux_q          <= `RST_AUX;
      carry_q        <= 1'b0;
      sum_ovf_q      <= 1'b0;
      cond_q         <= `RST_COND;
      illegal_seen_q <= 1'b0;
    end else begin
      mode64_q       <= mode64_d;
      aux_q          <= aux_d;
      carry_q        <= carry_d;
      sum_ovf_q      <= sum_ovf_d;
      cond_q         <= cond_d;
      illegal_seen_q <= illegal_seen_d;
    end
  end

  // apb answer registers
  // pready comes from a flop: one fixed wait state buys a clean output
  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= apb_access;
      PSLVERR_O <= apb_access && !addr_ok;
      if (apb_rd) begin
        PRDATA_O <= rd_mux; // sampled before this cycle's updates land
      end
    end
  end

  // write-back pulses and mirrors, one cycle after issue
  // a trapped doubleword still raises done so issue can retire it
  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      DONE_O            <= 1'b0;
      DEST_WE_O         <= 1'b0;
      COND_WE_O         <= 1'b0;
      COND_FIELD_ZERO_O <= `RST_COND;
      SHIFT_OUT_WE_O    <= 1'b0;
      SHIFT_OUT_FLAG_O  <= 1'b0;
      AUX_REG_O         <= `RST_AUX;
      ILLEGAL_INSTR_O   <= 1'b0;
    end else begin
      DONE_O            <= is_ours;
      DEST_WE_O         <= exec;
      ILLEGAL_INSTR_O   <= illegal;
      COND_WE_O         <= rec_exec;
      SHIFT_OUT_WE_O    <= sign_exec;
      // mirrors follow the stored state so both always agree
      COND_FIELD_ZERO_O <= cond_d;
      SHIFT_OUT_FLAG_O  <= carry_d;
      AUX_REG_O         <= aux_d;
    end
  end

  // destination and index hold until the next executed shift, so a
  // write port that stalls can still pick them up a cycle late
  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      DEST_IDX_O <= {IDX_W{1'b0}};
      DEST_GPR_O <= 64'h0000_0000_0000_0000;
    end else if (exec) begin
      DEST_IDX_O <= DEST_IDX_I;
      DEST_GPR_O <= result;
    end
  end

endmodule // shift_right_ext_unit

// ---- bench/shift_right_ext_props.sv ----
`timescale 1ns/1ns
// write-back checks against the issued operands
module shift_right_ext_props (
  // clock and reset
  input wire        SYS_CLK_I,
  input wire        RESET_I,
  // issue
  input wire        ISSUE_VALID_I,
  input wire [5:0]  PRIMARY_OP_I,
  input wire [9:0]  EXTENDED_OP_I,
  input wire        RECORD_BIT_I,
  input wire [63:0] SOURCE_GPR_I,
  input wire [63:0] AMOUNT_GPR_I,
  // write back
  input wire        DONE_O,
  input wire        DEST_WE_O,
  input wire [63:0] DEST_GPR_O,
  input wire        COND_WE_O,
  input wire [3:0]  COND_FIELD_ZERO_O,
  input wire        SHIFT_OUT_WE_O,
  input wire        SHIFT_OUT_FLAG_O,
  input wire [31:0] AUX_REG_O,
  input wire        ILLEGAL_INSTR_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // decoded issue strobes
  wire        iss  = ISSUE_VALID_I && PRIMARY_OP_I == 6'h1f;
  wire        i_dw = iss && EXTENDED_OP_I == 10'h21b;
  wire        i_zr = iss && EXTENDED_OP_I == 10'h299;
  wire        i_sg = iss && EXTENDED_OP_I == 10'h399;
  // rotate right by n is rotate left by 32-n, so a doubled word does it
  wire [6:0]  amt7 = AMOUNT_GPR_I[6:0];
  wire [63:0] dd   = {SOURCE_GPR_I[31:0], SOURCE_GPR_I[31:0]} >> AMOUNT_GPR_I[4:0];
  wire [31:0] rot  = dd[31:0];
  wire [31:0] msk  = 32'hffff_ffff >> AMOUNT_GPR_I[4:0];
  wire [31:0] zres = rot & msk;
  wire [31:0] sres = zres | ({32{SOURCE_GPR_I[31]}} & ~msk);
  wire        cy   = |(rot & ~msk) & SOURCE_GPR_I[31];

  a_dword_shift: assert property (i_dw |=> !DEST_WE_O ||
    DEST_GPR_O == $past(SOURCE_GPR_I) >> $past(amt7)) else $error("dword result");
  a_dword_over: assert property (i_dw && amt7[6] |=> !DEST_WE_O || DEST_GPR_O == 64'h0)
    else $error("dword overrange");
  a_dword_legal: assert property (i_dw |=> DONE_O && DEST_WE_O != ILLEGAL_INSTR_O)
    else $error("dword legality");
  a_norec_cond: assert property (iss && !RECORD_BIT_I |=> !COND_WE_O
    && $stable(COND_FIELD_ZERO_O)) else $error("cond touched");
  a_rec_cond: assert property ((i_zr || i_sg) && RECORD_BIT_I |=> COND_WE_O &&
    $onehot(COND_FIELD_ZERO_O[3:1]) && COND_FIELD_ZERO_O[3] == DEST_GPR_O[31])
    else $error("cond value");
  a_zero_keep: assert property (i_zr |=> !SHIFT_OUT_WE_O && $stable(SHIFT_OUT_FLAG_O))
    else $error("carry touched");
  a_sign_carry: assert property (i_sg |=> SHIFT_OUT_WE_O &&
    SHIFT_OUT_FLAG_O == $past(cy)) else $error("carry value");
  a_aux_rotate: assert property (i_zr || i_sg |=> AUX_REG_O == $past(rot))
    else $error("aux value");
  a_zero_merge: assert property (i_zr |=> DEST_GPR_O == {32'h0, $past(zres)})
    else $error("zero fill");
  a_sign_merge: assert property (i_sg |=> DEST_GPR_O == {32'h0, $past(sres)})
    else $error("sign fill");
endmodule // shift_right_ext_props

bind shift_right_ext_unit shift_right_ext_props u_props (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ISSUE_VALID_I(ISSUE_VALID_I),
  .PRIMARY_OP_I(PRIMARY_OP_I), .EXTENDED_OP_I(EXTENDED_OP_I), .RECORD_BIT_I(RECORD_BIT_I),
  .SOURCE_GPR_I(SOURCE_GPR_I), .AMOUNT_GPR_I(AMOUNT_GPR_I), .DONE_O(DONE_O),
  .DEST_WE_O(DEST_WE_O), .DEST_GPR_O(DEST_GPR_O), .COND_WE_O(COND_WE_O),
  .COND_FIELD_ZERO_O(COND_FIELD_ZERO_O), .SHIFT_OUT_WE_O(SHIFT_OUT_WE_O),
  .SHIFT_OUT_FLAG_O(SHIFT_OUT_FLAG_O), .AUX_REG_O(AUX_REG_O),
  .ILLEGAL_INSTR_O(ILLEGAL_INSTR_O)
);

// ---- bench/issue_model.sv ----
`timescale 1ns/1ns
// decode side: one-cycle issue pulses
module issue_model (
  // clock
  input  wire         clk,
  // issue lines
  output logic        vld = 1'b0,
  output logic [5:0]  pop = 6'h00,
  output logic [9:0]  xop = 10'h000,
  output logic        rec = 1'b0,
  output logic [4:0]  idx = 5'h00,
  output logic [63:0] src = 64'h0,
  output logic [63:0] amt = 64'h0
);
  // operands scrambled after the pulse so stale data never looks valid
  task automatic issue(input logic [9:0] x, input logic r, input logic [63:0] s, a);
    @(posedge clk);
    vld <= 1'b1;
    pop <= 6'h1f;
    xop <= x;
    rec <= r;
    idx <= idx + 5'h1;
    src <= s;
    amt <= a;
    @(posedge clk);
    vld <= 1'b0;
    xop <= ~x;
    src <= ~s;
    amt <= ~a;
  endtask
endmodule // issue_model

// ---- bench/test_shift_right_ext_unit.sv ----
`timescale 1ns/1ns
module test_shift_right_ext_unit;
  // bench state
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          checked = 0;
  wire         vld, rec;
  wire [5:0]   pop;
  wire [9:0]   xop;
  wire [4:0]   idx;
  wire [63:0]  src, amt;
  localparam logic [63:0] dw = 64'h8000_0000_0000_0001;

  // 25 MHz clock
  always #20 clk = ~clk;

  issue_model u_iss (.clk(clk), .vld(vld), .pop(pop), .xop(xop), .rec(rec), .idx(idx),
    .src(src), .amt(amt));

  shift_right_ext_unit dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(), .PREADY_O(), .PSLVERR_O(),
    .ISSUE_VALID_I(vld), .PRIMARY_OP_I(pop), .EXTENDED_OP_I(xop), .RECORD_BIT_I(rec),
    .DEST_IDX_I(idx), .SOURCE_GPR_I(src), .AMOUNT_GPR_I(amt), .DONE_O(), .DEST_WE_O(),
    .DEST_IDX_O(), .DEST_GPR_O(), .COND_WE_O(), .COND_FIELD_ZERO_O(), .SHIFT_OUT_WE_O(),
    .SHIFT_OUT_FLAG_O(), .AUX_REG_O(), .ILLEGAL_INSTR_O()
  );

  // compare and count
  task automatic chk(input string what, input logic [63:0] exp, got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // apb transfer, answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dut.PREADY_O !== 1'b1 && n < 20);
    rd = dut.PRDATA_O;
    er = dut.PSLVERR_O;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("[FAIL] pready expected 1 seen %b", dut.PREADY_O);
    end
  endtask

  // one instruction, write-back looked at in its single cycle
  task automatic ex(input logic [9:0] x, input logic r, input logic [63:0] s, a, d,
      input logic [31:0] q, input logic c, input logic [3:0] f);
    u_iss.issue(x, r, s, a);
    #1;
    chk("dest", d, dut.DEST_GPR_O);
    chk("aux", q, dut.AUX_REG_O);
    chk("carry", c, dut.SHIFT_OUT_FLAG_O);
    chk("cond", f, dut.COND_FIELD_ZERO_O);
    chk("done", 64'h1, dut.DONE_O);
    chk("write en", 64'h1, dut.DEST_WE_O);
    chk("dest idx", {59'h0, idx}, dut.DEST_IDX_O);
    chk("cond we", {63'h0, r}, dut.COND_WE_O);
    chk("carry we", {63'h0, x == 10'h399}, dut.SHIFT_OUT_WE_O);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the under one hundred cycles needed
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // register block
    apb(1'b0, 8'h00, 32'h0);
    chk("mode64", 64'h1, rd);
    apb(1'b1, 8'h04, 32'h1234_5678);
    apb(1'b0, 8'h04, 32'h0);
    chk("aux rw", 64'h1234_5678, rd);
    chk("aux err", 64'h0, er);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 64'h1, er);
    $display("test apb done");
    // word shifts; non-record forms must leave the condition field alone
    ex(10'h299, 0, 64'h5a5a_5a5a_9000_3000, 64'he0c, 64'h9_0003, 32'h9_0003, 0, 4'h0);
    ex(10'h399, 0, 64'h9000_300f, 64'h4, 64'hf900_0300, 32'hf900_0300, 1, 4'h0);
    ex(10'h299, 1, 64'hb004_3000, 64'hf, 64'h1_6008, 32'h6001_6008, 1, 4'h4);
    ex(10'h399, 1, 64'hb004_3000, 64'h4, 64'hfb00_4300, 32'hb00_4300, 0, 4'h8);
    ex(10'h399, 0, 64'h7000_000f, 64'h4, 64'h700_0000, 32'hf700_0000, 0, 4'h8);
    ex(10'h399, 0, 64'h8000_0001, 64'h0, 64'h8000_0001, 32'h8000_0001, 0, 4'h8);
    ex(10'h399, 1, 64'h8000_0002, 64'h1f, 64'hffff_ffff, 32'h5, 1, 4'h8);
    apb(1'b1, 8'h08, 32'h2);
    ex(10'h299, 1, 64'h0, 64'h5, 64'h0, 32'h0, 0, 4'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk("except", 64'h2, rd);
    $display("test word done");
    // doubleword: in range, boundary 64, top 127, high amount bits ignored
    ex(10'h21b, 0, dw, 64'h3f, 64'h1, 32'h0, 0, 4'h3);
    ex(10'h21b, 0, dw, 64'h40, 64'h0, 32'h0, 0, 4'h3);
    ex(10'h21b, 0, dw, 64'h7f, 64'h0, 32'h0, 0, 4'h3);
    ex(10'h21b, 0, dw, 64'hffff_ff81, 64'h4000_0000_0000_0000, 32'h0, 0, 4'h3);
    ex(10'h21b, 1, dw, 64'h0, dw, 32'h0, 0, 4'h9);
    $display("test dword done");
    // narrow mode refuses the doubleword shift
    apb(1'b1, 8'h00, 32'h0);
    u_iss.issue(10'h21b, 1'b0, 64'h1, 64'h0);
    #1;
    chk("illegal", 64'h1, dut.ILLEGAL_INSTR_O);
    chk("dest we", 64'h0, dut.DEST_WE_O);
    apb(1'b0, 8'h0c, 32'h0);
    chk("sticky", 64'h1, rd[4]);
    chk("status cond", 64'h9, rd[3:0]);
    $display("test illegal done");
    tally_and_finish();
  end
endmodule // test_shift_right_ext_unit
